// ---- rtl/jlp_checksum.sv ----
// Purpose: registered lane checksum over the current link parameters
// Assumes: parameters come straight from the register bank flops
// Notes:   one cycle behind the parameters; the bank's read pipeline hides that for writes taken before a read request
`timescale 1ns/1ps
module jlp_checksum
   import jlp_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire jlp_cfg_t   cfg,
   output logic [7:0]      checksum
);

   typedef struct packed {
      logic [7:0] sum;
   } jlp_chk_state_t;

   jlp_chk_state_t state;
   jlp_chk_state_t next_state;

   // ==========================================================================
   // recompute every cycle so no write can be missed
   always_comb
   begin
      next_state     = state;
      next_state.sum = jlp_sum(cfg);
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         state <= '0;
      else
         state <= next_state;
   end

   assign checksum = state.sum;

endmodule

// ---- rtl/jlp_link_param_regs.sv ----
// Purpose: link configuration parameter registers of a one-lane serial ADC transmitter
// Assumes: requests arrive from the serial control port decoder on the same clock
// Notes:   reads answer two cycles after the request; writes land at the request edge
`timescale 1ns/1ps
module jlp_link_param_regs
   import jlp_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire jlp_req_t   req,
   output jlp_resp_t       rsp,
   output jlp_cfg_t        cfg,
   output logic [7:0]      checksum
);

   // ==========================================================================
   // state
   typedef struct packed {
      jlp_cfg_t   cfg;
      logic       rd_pend;
      logic [7:0] rd_addr;
      jlp_resp_t  rsp;
   } jlp_bank_state_t;

   jlp_bank_state_t state;
   jlp_bank_state_t next_state;
   logic [7:0]      chk;

   // ==========================================================================
   // read value of one address; open bits and unmapped addresses read zero
   function automatic logic [7:0] read_value(input jlp_cfg_t   c,
                                             input logic [7:0] a,
                                             input logic [7:0] s);
      logic [7:0] v;
      v = READ_UNMAPPED;
      case (a)
         ADDR_DEVICE_ID:  v = c.device_id;
         ADDR_BANK_ID:    v = {4'h0, c.bank_id};
         ADDR_LANE_ID:    v = {3'h0, c.lane_id};
         ADDR_SCR_LANE:   v = {c.scr, 6'h00, c.lane};
         ADDR_OCTETS:     v = jlp_octets(c.conv, c.lane);
         ADDR_FRAMES_MF:  v = {3'h0, c.frames_mf};
         ADDR_CONV_COUNT: v = {7'h00, c.conv};
         ADDR_RES_CTRL:   v = {c.cs, 1'b0, RESOLUTION_M1};
         ADDR_TOTAL_BITS: v = {3'h0, TOTAL_BITS_M1};
         ADDR_SAMPLES:    v = {3'h0, SAMPLES_M1};
         ADDR_DENSITY_CW: v = {HIGH_DENSITY, 2'h0, CTRL_WORDS};
         ADDR_USER_ONE:   v = c.user_one;
         ADDR_USER_TWO:   v = c.user_two;
         ADDR_CHECKSUM:   v = s;
         default:         v = READ_UNMAPPED;
      endcase
      return v;
   endfunction

   // ==========================================================================
   // checksum flop, kept apart so its adder tree stays off the read path
   jlp_checksum u_checksum
   (
      .clock    (clock),
      .rst      (rst),
      .cfg      (state.cfg),
      .checksum (chk)
   );

   // ==========================================================================
   // next state: read pipeline then write decode
   always_comb
   begin
      next_state           = state;
      next_state.rd_pend   = 1'b0;
      next_state.rsp.valid = 1'b0;
      // second read stage: by now the checksum has caught up with any write taken before the read request
      if (state.rd_pend)
      begin
         next_state.rsp.valid = 1'b1;
         next_state.rsp.data  = read_value(state.cfg, state.rd_addr, chk);
      end
      if (req.valid && !req.write)
      begin
         next_state.rd_pend = 1'b1;
         next_state.rd_addr = req.addr;
      end
      // read-only addresses are left out, so writes to them have no effect
      if (req.valid && req.write)
      begin
         case (req.addr)
            ADDR_DEVICE_ID:  next_state.cfg.device_id = req.wdata;
            ADDR_BANK_ID:    next_state.cfg.bank_id   = req.wdata[3:0];
            ADDR_LANE_ID:    next_state.cfg.lane_id   = req.wdata[4:0];
            ADDR_SCR_LANE:
            begin
               next_state.cfg.scr  = req.wdata[SCR_BIT];
               // the reserved setting is stored as written; software keeps it zero
               next_state.cfg.lane = req.wdata[LANE_BIT];
            end
            ADDR_FRAMES_MF:  next_state.cfg.frames_mf = req.wdata[4:0];
            ADDR_CONV_COUNT: next_state.cfg.conv = req.wdata[CONV_BIT];
            ADDR_RES_CTRL:   next_state.cfg.cs = req.wdata[CS_MSB:CS_LSB];
            ADDR_USER_ONE:   next_state.cfg.user_one = req.wdata;
            ADDR_USER_TWO:   next_state.cfg.user_two = req.wdata;
            default:         next_state.cfg = state.cfg;
         endcase
      end
   end

   // ==========================================================================
   // state register
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state               <= '0;
         state.cfg.device_id <= RST_DEVICE_ID;
         state.cfg.bank_id   <= RST_BANK_ID;
         state.cfg.lane_id   <= RST_LANE_ID;
         state.cfg.scr       <= RST_SCR;
         state.cfg.lane      <= RST_LANE;
         state.cfg.frames_mf <= RST_FRAMES_MF;
         state.cfg.conv      <= RST_CONV;
         state.cfg.cs        <= RST_CS;
         state.cfg.user_one  <= RST_USER;
         state.cfg.user_two  <= RST_USER;
      end
      else
         state <= next_state;
   end

   // ==========================================================================
   // outputs, all from flops; the link is expected held in power-down while
   // these change, so no shadowing against mid-frame updates is done
   assign rsp      = state.rsp;
   assign cfg      = state.cfg;
   assign checksum = chk;

   // ==========================================================================
   // assertions
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   logic rd_take;
   logic wr_take;
   assign rd_take = req.valid && !req.write;
   assign wr_take = req.valid && req.write;

   function automatic logic rd_of(input jlp_req_t r, input logic [7:0] a);
      return r.valid && !r.write && (r.addr == a);
   endfunction

   function automatic logic wr_of(input jlp_req_t r, input logic [7:0] a);
      return r.valid && r.write && (r.addr == a);
   endfunction

   a_read_latency: assert property (rsp.valid == $past(rd_take, 2))
      else $error("read answer not exactly two cycles after request");

   a_device_id: assert property (rd_of(req, ADDR_DEVICE_ID) |-> ##2
         rsp.data == $past(cfg.device_id))
      else $error("device identifier readback wrong");

   a_device_wr: assert property (wr_of(req, ADDR_DEVICE_ID) |=>
         cfg.device_id == $past(req.wdata) && cfg.bank_id == $past(cfg.bank_id))
      else $error("device identifier write not taken");

   a_bank_open: assert property (rd_of(req, ADDR_BANK_ID) |-> ##2
         rsp.data[7:4] == 4'h0 && rsp.data[3:0] == $past(cfg.bank_id))
      else $error("bank identifier readback wrong");

   a_lane_id: assert property (wr_of(req, ADDR_LANE_ID) ##1 !wr_take |-> ##1
         cfg.lane_id == $past(req.wdata[4:0], 2))
      else $error("lane identifier not kept");

   a_scr_write: assert property (wr_of(req, ADDR_SCR_LANE) |=>
         cfg.scr == $past(req.wdata[SCR_BIT]) && cfg.lane == $past(req.wdata[LANE_BIT]))
      else $error("scrambler or lane bit write wrong");

   a_octets_val: assert property (rd_of(req, ADDR_OCTETS) |-> ##2
         rsp.data == jlp_octets($past(cfg.conv), $past(cfg.lane)))
      else $error("octets per frame readback wrong");

   a_octets_base: assert property (rd_of(req, ADDR_OCTETS) ##1
         (!cfg.conv && !cfg.lane) |-> ##1 rsp.data == 8'h02)
      else $error("octets per frame not two for one converter one lane");

   a_frames_mf: assert property (wr_of(req, ADDR_FRAMES_MF) |=>
         cfg.frames_mf == $past(req.wdata[4:0]))
      else $error("frames per multiframe write wrong");

   a_conv_bit: assert property (wr_of(req, ADDR_CONV_COUNT) |=>
         cfg.conv == $past(req.wdata[0]))
      else $error("converter count bit write wrong");

   a_res_ctrl: assert property (rd_of(req, ADDR_RES_CTRL) |-> ##2
         rsp.data == {$past(cfg.cs), 1'b0, 5'h0d})
      else $error("resolution and control bits readback wrong");

   a_res_ro: assert property (wr_of(req, ADDR_RES_CTRL) |=>
         cfg.cs == $past(req.wdata[7:6]) && cfg.device_id == $past(cfg.device_id))
      else $error("resolution register write disturbed state");

   a_fixed_ro: assert property (rd_of(req, ADDR_TOTAL_BITS) |-> ##2
         rsp.data == 8'h0f)
      else $error("total bits per sample not fifteen");

   a_samples_ro: assert property (rd_of(req, ADDR_SAMPLES) |-> ##2
         rsp.data == 8'h00)
      else $error("samples per frame not zero");

   a_format_ro: assert property (rd_of(req, ADDR_DENSITY_CW) |-> ##2
         rsp.data[7] == 1'b0 && rsp.data[4:0] == 5'h00)
      else $error("density or control words not zero");

   a_ro_unwritten: assert property (wr_of(req, ADDR_DENSITY_CW) |=>
         cfg == $past(cfg))
      else $error("write to read-only format register changed state");

   a_user_regs: assert property (wr_of(req, ADDR_USER_TWO) ##1
         rd_of(req, ADDR_USER_TWO) |-> ##2 rsp.data == $past(req.wdata, 3))
      else $error("user register two did not read back");

   a_chk_read: assert property (rd_of(req, ADDR_CHECKSUM) |-> ##2
         rsp.data == jlp_sum($past(cfg)))
      else $error("checksum readback wrong");

   a_chk_fresh: assert property (wr_take ##1 rd_of(req, ADDR_CHECKSUM) |-> ##2
         rsp.data == jlp_sum($past(cfg, 2)))
      else $error("checksum stale after write");

   // ==========================================================================
   // field by field: writes land only where aimed, reads show the stored field
   a_bank_wr: assert property (wr_of(req, ADDR_BANK_ID) |=>
         cfg.bank_id == $past(req.wdata[3:0]))
      else $error("bank identifier write wrong");

   a_lane_rd: assert property (rd_of(req, ADDR_LANE_ID) |-> ##2
         rsp.data == {3'h0, $past(cfg.lane_id)})
      else $error("lane identifier readback wrong");

   a_lane_keep: assert property (wr_of(req, ADDR_LANE_ID) |=>
         cfg.bank_id == $past(cfg.bank_id) && cfg.device_id == $past(cfg.device_id))
      else $error("lane identifier write disturbed other fields");

   a_scr_rd: assert property (rd_of(req, ADDR_SCR_LANE) |-> ##2
         rsp.data == {$past(cfg.scr), 6'h00, $past(cfg.lane)})
      else $error("scrambler and lane readback wrong");

   a_lane_one: assert property (rd_of(req, ADDR_OCTETS) ##1
         (!cfg.conv && cfg.lane) |-> ##1 rsp.data == 8'h01)
      else $error("octets per frame wrong with reserved lane setting");

   a_octets_ro: assert property (wr_of(req, ADDR_OCTETS) |=>
         cfg == $past(cfg))
      else $error("write to octets per frame changed state");

   a_frames_rd: assert property (rd_of(req, ADDR_FRAMES_MF) |-> ##2
         rsp.data == {3'h0, $past(cfg.frames_mf)})
      else $error("frames per multiframe readback wrong");

   a_conv_rd: assert property (rd_of(req, ADDR_CONV_COUNT) |-> ##2
         rsp.data == {7'h00, $past(cfg.conv)})
      else $error("converter count readback wrong");

   a_conv_two: assert property (rd_of(req, ADDR_OCTETS) ##1
         (cfg.conv && !cfg.lane) |-> ##1 rsp.data == 8'h04)
      else $error("octets per frame wrong with reserved converter setting");

   a_cs_code: assert property (wr_of(req, ADDR_RES_CTRL) |=>
         cfg.frames_mf == $past(cfg.frames_mf) && cfg.conv == $past(cfg.conv))
      else $error("control bits write disturbed other fields");

   a_res_rd: assert property (rd_of(req, ADDR_RES_CTRL) |-> ##2
         rsp.data[5:0] == 6'h0d)
      else $error("resolution field not thirteen");

   a_total_ro: assert property (wr_of(req, ADDR_TOTAL_BITS) |=>
         cfg == $past(cfg))
      else $error("write to total bits per sample changed state");

   a_samples_wr: assert property (wr_of(req, ADDR_SAMPLES) |=>
         cfg == $past(cfg))
      else $error("write to samples per frame changed state");

   a_density_rd: assert property (rd_of(req, ADDR_DENSITY_CW) |-> ##2
         rsp.data == 8'h00)
      else $error("format register not all zero");

   a_user_one: assert property (wr_of(req, ADDR_USER_ONE) |=>
         cfg.user_one == $past(req.wdata))
      else $error("user register one write wrong");

   a_user_rd: assert property (rd_of(req, ADDR_USER_ONE) |-> ##2
         rsp.data == $past(cfg.user_one))
      else $error("user register one readback wrong");

   a_user_two_wr: assert property (wr_of(req, ADDR_USER_TWO) |=>
         cfg.user_two == $past(req.wdata) && cfg.user_one == $past(cfg.user_one))
      else $error("user register two write wrong");

   a_chk_ro: assert property (wr_of(req, ADDR_CHECKSUM) |=>
         cfg == $past(cfg))
      else $error("write to checksum changed state");

   a_chk_track: assert property (!$past(rst) |->
         checksum == jlp_sum($past(cfg)))
      else $error("checksum output not tracking parameters");

   a_chk_resp: assert property (rd_of(req, ADDR_CHECKSUM) |-> ##2
         rsp.data == $past(checksum))
      else $error("checksum read differs from checksum output");

   a_cfg_quiet: assert property (!wr_take |=>
         cfg == $past(cfg))
      else $error("parameters changed without a write");

   a_rsp_hold: assert property (!rsp.valid |->
         $stable(rsp.data))
      else $error("read data changed without an answer");

   c_write_then_chk: cover property (wr_of(req, ADDR_DEVICE_ID) ##1 rd_of(req, ADDR_CHECKSUM));
   c_scr_on: cover property (wr_of(req, ADDR_SCR_LANE) ##1 cfg.scr);
   c_octets_read: cover property (rd_of(req, ADDR_OCTETS) ##2 rsp.valid);
   c_back_to_back: cover property (rd_take ##1 rd_take ##1 rd_take);
   c_lane_reserved: cover property (rd_of(req, ADDR_OCTETS) ##1 cfg.lane);

endmodule

// ---- rtl/jlp_pkg.sv ----
// Purpose: shared constants, carriers and helpers for the link parameter register bank
// Assumes: one 100 MHz control clock, 8-bit registers addressed by an 8-bit index
// Notes:   all parameter fields reset to zero; read-only fields other than octets per frame and checksum are fixed constants
package jlp_pkg;

   // ==========================================================================
   // register addresses
   localparam logic [7:0] ADDR_DEVICE_ID   = 8'h64;
   localparam logic [7:0] ADDR_BANK_ID     = 8'h65;
   localparam logic [7:0] ADDR_LANE_ID     = 8'h66;
   localparam logic [7:0] ADDR_SCR_LANE    = 8'h6e;
   localparam logic [7:0] ADDR_OCTETS      = 8'h6f;
   localparam logic [7:0] ADDR_FRAMES_MF   = 8'h70;
   localparam logic [7:0] ADDR_CONV_COUNT  = 8'h71;
   localparam logic [7:0] ADDR_RES_CTRL    = 8'h72;
   localparam logic [7:0] ADDR_TOTAL_BITS  = 8'h73;
   localparam logic [7:0] ADDR_SAMPLES     = 8'h74;
   localparam logic [7:0] ADDR_DENSITY_CW  = 8'h75;
   localparam logic [7:0] ADDR_USER_ONE    = 8'h76;
   localparam logic [7:0] ADDR_USER_TWO    = 8'h77;
   localparam logic [7:0] ADDR_CHECKSUM    = 8'h78;

   // ==========================================================================
   // field positions
   localparam int SCR_BIT   = 7;
   localparam int LANE_BIT  = 0;
   localparam int CONV_BIT  = 0;
   localparam int CS_MSB    = 7;
   localparam int CS_LSB    = 6;
   localparam int HD_BIT    = 7;

   // ==========================================================================
   // reset values of the writable fields
   localparam logic [7:0] RST_DEVICE_ID  = 8'h00;
   localparam logic [3:0] RST_BANK_ID    = 4'h0;
   localparam logic [4:0] RST_LANE_ID    = 5'h00;
   localparam logic       RST_SCR        = 1'b0;
   localparam logic       RST_LANE       = 1'b0;
   localparam logic [4:0] RST_FRAMES_MF  = 5'h00;
   localparam logic       RST_CONV       = 1'b0;
   localparam logic [1:0] RST_CS         = 2'h0;
   localparam logic [7:0] RST_USER       = 8'h00;

   // ==========================================================================
   // fixed read-only values
   localparam logic [4:0] RESOLUTION_M1  = 5'h0d;
   localparam logic [4:0] TOTAL_BITS_M1  = 5'h0f;
   localparam logic [4:0] SAMPLES_M1     = 5'h00;
   localparam logic       HIGH_DENSITY   = 1'b0;
   localparam logic [4:0] CTRL_WORDS     = 5'h00;
   localparam logic [7:0] OCTETS_ONE_CONV = 8'h02;
   localparam logic [7:0] OCTETS_TWO_CONV = 8'h04;
   localparam logic [7:0] READ_UNMAPPED  = 8'h00;

   // ==========================================================================
   // carriers
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } jlp_req_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } jlp_resp_t;

   typedef struct packed {
      logic [7:0] device_id;
      logic [3:0] bank_id;
      logic [4:0] lane_id;
      logic       scr;
      logic       lane;
      logic [4:0] frames_mf;
      logic       conv;
      logic [1:0] cs;
      logic [7:0] user_one;
      logic [7:0] user_two;
   } jlp_cfg_t;

   // ==========================================================================
   // octets per frame = converters * 2 / lanes, from the one-bit encodings
   function automatic logic [7:0] jlp_octets(input logic conv, input logic lane);
      logic [7:0] m2;
      m2 = conv ? OCTETS_TWO_CONV : OCTETS_ONE_CONV;
      return lane ? {1'b0, m2[7:1]} : m2;
   endfunction

   // sum of every lane parameter as carried on the link, wrapping at 256
   function automatic logic [7:0] jlp_sum(input jlp_cfg_t c);
      logic [7:0] s;
      s = c.device_id;
      s = s + {4'h0, c.bank_id};
      s = s + {3'h0, c.lane_id};
      s = s + {7'h00, c.scr};
      s = s + {7'h00, c.lane};
      s = s + (jlp_octets(c.conv, c.lane) - 8'h01);
      s = s + {3'h0, c.frames_mf};
      s = s + {7'h00, c.conv};
      s = s + {3'h0, RESOLUTION_M1};
      s = s + {6'h00, c.cs};
      s = s + {3'h0, TOTAL_BITS_M1};
      s = s + {3'h0, SAMPLES_M1};
      s = s + {7'h00, HIGH_DENSITY};
      s = s + {3'h0, CTRL_WORDS};
      s = s + c.user_one;
      s = s + c.user_two;
      return s;
   endfunction

endpackage

// ---- sim/jlp_host_model.sv ----
// Purpose: host side of the register port, issuing reads and writes like the control decoder
// Assumes: requests change 1 ns after a rising edge and are taken at the next edge
// Notes:   released address and data lines show the inverse of their last value
`timescale 1ns/1ps
module jlp_host_model
   import jlp_pkg::*;
(
   input  wire logic      clock,
   input  wire logic      rst,
   output jlp_req_t       req,
   input  wire jlp_resp_t rsp
);
   // ==========================================================================
   // request driving
   // idle at time zero; valid stays low while rst is high because the bench
   // only pulses reset between transfers
   initial req = '{valid: 1'b0, write: 1'b0, addr: 8'h00, wdata: 8'h00};

   // parameter writes are issued while the transmitter is held powered down
   // by the caller, so the link never sees a half-changed set
   task automatic issue(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      #1;
      req = '{valid: 1'b1, write: wr, addr: a, wdata: d};
   endtask

   // release the port; stale address must not look like a live one
   task automatic idle();
      @(posedge clock);
      #1;
      req = '{valid: 1'b0, write: ~req.write, addr: ~req.addr, wdata: ~req.wdata};
   endtask

   // slow pacing between requests
   task automatic pause(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // ==========================================================================
   // answer collection
   // takes the standing answer, waiting up to six cycles for one, then steps one cycle so the next call sees the next one;
   // a missing answer is returned as unknown so the caller's compare fails
   task automatic collect(output logic [7:0] d);
      int n;
      d = 8'hxx;
      for (n = 0; n < 6 && rsp.valid !== 1'b1; n++)
      begin
         @(posedge clock);
         #1;
      end
      if (rsp.valid === 1'b1)
         d = rsp.data;
      @(posedge clock);
      #1;
   endtask
endmodule

// ---- sim/tb.sv ----
// Purpose: self-checking bench for the link parameter register bank
// Assumes: reads answer two cycles after the request, writes land at the request edge
// Notes:   expected sums are worked out by hand from the field encodings
`timescale 1ns/1ps
module tb;
   import jlp_pkg::*;
   logic       clock;
   logic       rst;
   jlp_req_t   req;
   jlp_resp_t  rsp;
   jlp_cfg_t   cfg;
   logic [7:0] checksum;
   logic [7:0] rd;
   int         errors;
   int         check_count;
   int         cycles;

   // ==========================================================================
   // instances
   jlp_link_param_regs i_dut (.clock(clock), .rst(rst), .req(req), .rsp(rsp),
                              .cfg(cfg), .checksum(checksum));
   jlp_host_model i_host (.clock(clock), .rst(rst), .req(req), .rsp(rsp));

   // ==========================================================================
   // clock, reset and hang guard
   initial clock = 1'b0;
   always #5 clock = ~clock;

   // the whole run needs well under a thousand cycles
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         errors++;
         $display("CHECK FAILED at %0t: run did not finish", $time);
         close_out();
      end
   end

   // ==========================================================================
   // helpers
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      i_host.issue(1'b0, a, 8'h00);
      i_host.idle();
      i_host.collect(d);
   endtask

   task automatic close_out();
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ==========================================================================
   // scenarios
   // every mapped place after reset, plus one hole in the map
   task automatic test_reset_values();
      logic [7:0] a [15] = '{8'h64, 8'h65, 8'h66, 8'h6e, 8'h6f, 8'h70, 8'h71, 8'h72,
                             8'h73, 8'h74, 8'h75, 8'h76, 8'h77, 8'h78, 8'h67};
      logic [7:0] e [15] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h0d,
                             8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1d, 8'h00};
      check({7'h00, cfg === '0}, 8'h01);
      for (int i = 0; i < 15; i++)
      begin
         rd_reg(a[i], rd);
         check(rd, e[i]);
      end
   endtask

   // ones into most places, patterns into the scrambler/lane, converter, control and user places: open bits drop, read-only places keep their value
   task automatic test_write_masks();
      logic [7:0] a [15] = '{8'h64, 8'h65, 8'h66, 8'h6e, 8'h6f, 8'h70, 8'h71, 8'h72,
                             8'h73, 8'h74, 8'h75, 8'h76, 8'h77, 8'h78, 8'h67};
      logic [7:0] w [15] = '{8'hff, 8'hff, 8'hff, 8'hfe, 8'hff, 8'hff, 8'hfe, 8'hbf,
                             8'hff, 8'hff, 8'hff, 8'ha5, 8'h5a, 8'hff, 8'hff};
      logic [7:0] e [15] = '{8'hff, 8'h0f, 8'h1f, 8'h80, 8'h02, 8'h1f, 8'h00, 8'h8d,
                             8'h0f, 8'h00, 8'h00, 8'ha5, 8'h5a, 8'h6b, 8'h00};
      for (int i = 0; i < 15; i++)
      begin
         i_host.issue(1'b1, a[i], w[i]);
      end
      i_host.idle();
      for (int i = 0; i < 15; i++)
      begin
         rd_reg(a[i], rd);
         check(rd, e[i]);
      end
      check({7'h00, cfg.scr}, 8'h01);
      check({7'h00, cfg.lane}, 8'h00);
      check(checksum, 8'h6b);
      check(cfg.device_id, 8'hff);
      check({3'h0, cfg.frames_mf}, 8'h1f);
      check(cfg.user_two, 8'h5a);
   endtask

   // write then two pipelined reads with no gap: the sum must already be fresh
   task automatic test_back_to_back();
      logic [7:0] d2;
      i_host.issue(1'b1, ADDR_USER_ONE, 8'h11);
      i_host.issue(1'b0, ADDR_CHECKSUM, 8'h00);
      i_host.issue(1'b0, ADDR_USER_ONE, 8'h00);
      i_host.idle();
      i_host.collect(rd);
      i_host.collect(d2);
      check(rd, 8'hd7);
      check(d2, 8'h11);
      check(checksum, 8'hd7);
   endtask

   // every control-bits code, with the resolution bits written to ones
   task automatic test_cs_codes();
      for (int c = 0; c < 4; c++)
      begin
         i_host.issue(1'b1, ADDR_RES_CTRL, {c[1:0], 6'h3f});
         i_host.idle();
         i_host.pause(2);
         rd_reg(ADDR_RES_CTRL, rd);
         check(rd, {c[1:0], 1'b0, 5'h0d});
         check({6'h00, cfg.cs}, {6'h00, c[1:0]});
      end
   endtask

   // reserved lane and converter settings are stored; octets and sum follow them
   task automatic test_reserved();
      i_host.issue(1'b1, ADDR_SCR_LANE, 8'h81);
      rd_reg(ADDR_OCTETS, rd);
      check(rd, 8'h01);
      i_host.issue(1'b1, ADDR_CONV_COUNT, 8'h01);
      rd_reg(ADDR_OCTETS, rd);
      check(rd, 8'h02);
      i_host.issue(1'b1, ADDR_SCR_LANE, 8'h80);
      rd_reg(ADDR_OCTETS, rd);
      check(rd, 8'h04);
      rd_reg(ADDR_CHECKSUM, rd);
      check(rd, 8'hdb);
      check(checksum, 8'hdb);
      i_host.issue(1'b1, ADDR_USER_TWO, 8'h3c);
      i_host.issue(1'b0, ADDR_USER_TWO, 8'h00);
      i_host.idle();
      i_host.collect(rd);
      check(rd, 8'h3c);
   endtask

   // reset in mid-run clears everything back to the power-up set
   task automatic test_mid_reset();
      rst = 1'b1;
      i_host.pause(2);
      check({7'h00, cfg === '0}, 8'h01);
      check(checksum, 8'h00);
      rst = 1'b0;
      i_host.pause(2);
      rd_reg(ADDR_CHECKSUM, rd);
      check(rd, 8'h1d);
      rd_reg(ADDR_USER_TWO, rd);
      check(rd, 8'h00);
   endtask

   // ==========================================================================
   // main sequence
   initial
   begin
      errors = 0;
      check_count = 0;
      cycles = 0;
      rst = 1'b1;
      repeat (3) @(posedge clock);
      #1;
      rst = 1'b0;
      test_reset_values();
      test_write_masks();
      test_back_to_back();
      test_cs_codes();
      test_reserved();
      test_mid_reset();
      close_out();
   end
endmodule
